// ---- design/wrs_pkg.sv ----
// Package of constants and carrier types for the wakeup reset sequencer.
package wrs_pkg;

    // ------------------------------------------------------------------
    // Timing and field layout
    // ------------------------------------------------------------------
    localparam int unsigned CLK_WINDOW_CYCLES = 2;
    localparam int unsigned CAUSE_W           = 3;
    localparam int unsigned SYNC_STAGES       = 2;

    // Code that the cause field carries after a wakeup reset.
    localparam logic [2:0] CAUSE_WAKEUP = 3'h1;
    // Code held before the first completed sequence.
    localparam logic [2:0] CAUSE_NONE   = 3'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        WRS_HOLD   = 3'b001,
        WRS_WINDOW = 3'b010,
        WRS_RUN    = 3'b100
    } wrs_state_t;

    typedef struct packed
    {
        logic proc_rst_b;
        logic periph_rst_b;
        logic proc_clk_en;
    } wrs_ctrl_t;

endpackage

// ---- design/wrs_sync.sv ----
// Two-stage level synchroniser onto the slow clock.
`timescale 1ns/100ps
module wrs_sync
#(
    parameter int unsigned STAGES = 2
)
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic din,
    output logic      dout
);

    logic [STAGES-1:0] chain_reg;

    // The first stage feeds only the next stage, never any other logic.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            chain_reg <= '0;
        else
            chain_reg <= {chain_reg[STAGES-2:0], din};
    end

    assign dout = chain_reg[STAGES-1];

endmodule

// ---- design/wrs_top.sv ----
// Wakeup reset sequencer: main-supply POR to processor and peripheral resets.
// Notes on behaviour
// - While the main-supply POR is active every reset output is held asserted, the backup reset untouched.
// - On power-up the POR output is synchronised to the slow clock before it steps the sequence.
// - After the synchronised power-on the processor clock runs for two slow-clock cycles with resets held.
// - When that window ends the processor reset and the other resets release together.
// - On that release the reset cause field is set to report a wakeup reset.
// - A falling main supply asserts the resets at once, with no slow-clock delay.
// - That assertion is timed straight from the raw POR output, not its synchronised copy.
`timescale 1ns/100ps
module wrs_top
#(
    parameter int unsigned WINDOW_CYCLES = wrs_pkg::CLK_WINDOW_CYCLES
)
(
    input  wire logic                      sys_clk,
    input  wire logic                      rst_b,
    input  wire logic                      por_main_b,
    output logic                           proc_rst_b,
    output logic                           periph_rst_b,
    output logic                           proc_clk_en,
    output logic [wrs_pkg::CAUSE_W-1:0]    reset_cause_field
);

    // ------------------------------------------------------------------
    // Reset release and POR synchronisation
    // ------------------------------------------------------------------
    logic [1:0]          rst_sync_reg;
    logic                rst_int_b;
    logic                por_sync;
    logic                seq_rst_b;
    wrs_pkg::wrs_state_t state_reg;
    wrs_pkg::wrs_ctrl_t  ctrl_reg;

    // The window counter is sized from the parameter so that a longer
    // window still fits; it rests at the window length once released.
    localparam int unsigned         CNT_W    = $clog2(WINDOW_CYCLES + 1);
    localparam logic [CNT_W-1:0]    WIN_LAST = CNT_W'(WINDOW_CYCLES - 1);

    logic [CNT_W-1:0]    win_cnt_reg;
    logic                win_last;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    assign rst_int_b = rst_sync_reg[1];

    // The raw POR acts as an asynchronous clear of the sequence, so the
    // resets fall in the same instant as the supply, not a clock later.
    assign seq_rst_b = rst_int_b & por_main_b;

    wrs_sync
    #(
        .STAGES (wrs_pkg::SYNC_STAGES)
    )
    u_por_sync
    (
        .clk   (sys_clk),
        .rst_b (seq_rst_b),
        .din   (1'b1),
        .dout  (por_sync)
    );

    // ------------------------------------------------------------------
    // Sequence state
    // ------------------------------------------------------------------
    // Last cycle of the clock window; resets and cause move on this edge.
    assign win_last = (state_reg == wrs_pkg::WRS_WINDOW)
                      && (win_cnt_reg == WIN_LAST);

    always_ff @(posedge sys_clk or negedge seq_rst_b)
    begin
        if (!seq_rst_b)
        begin
            state_reg   <= wrs_pkg::WRS_HOLD;
            win_cnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                wrs_pkg::WRS_HOLD:
                begin
                    if (por_sync)
                        state_reg <= wrs_pkg::WRS_WINDOW;
                end
                wrs_pkg::WRS_WINDOW:
                begin
                    win_cnt_reg <= win_cnt_reg + CNT_W'(1);
                    if (win_last)
                        state_reg <= wrs_pkg::WRS_RUN;
                end
                wrs_pkg::WRS_RUN:
                    state_reg <= wrs_pkg::WRS_RUN;
                default:
                    state_reg <= wrs_pkg::WRS_HOLD;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Reset and clock controls
    // ------------------------------------------------------------------
    // Outputs come straight from these flops; the async clear drops them
    // with the supply.
    always_ff @(posedge sys_clk or negedge seq_rst_b)
    begin
        if (!seq_rst_b)
        begin
            ctrl_reg <= '{proc_rst_b: 1'b0, periph_rst_b: 1'b0,
                          proc_clk_en: 1'b0};
        end
        else
        begin
            // The clock comes on as the sequence leaves hold and is left
            // running after release, so the core never sees a stopped
            // clock between the window and its first instruction.
            ctrl_reg.proc_clk_en <= (state_reg == wrs_pkg::WRS_HOLD
                                     && por_sync)
                                    || state_reg == wrs_pkg::WRS_WINDOW
                                    || state_reg == wrs_pkg::WRS_RUN;
            if (win_last)
            begin
                ctrl_reg.proc_rst_b   <= 1'b1;
                ctrl_reg.periph_rst_b <= 1'b1;
            end
        end
    end

    // Cause survives the supply loss; only the power-on reset clears it.
    always_ff @(posedge sys_clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
            reset_cause_field <= wrs_pkg::CAUSE_NONE;
        else if (seq_rst_b && win_last)
            reset_cause_field <= wrs_pkg::CAUSE_WAKEUP;
    end

    assign proc_rst_b   = ctrl_reg.proc_rst_b;
    assign periph_rst_b = ctrl_reg.periph_rst_b;
    assign proc_clk_en  = ctrl_reg.proc_clk_en;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    hold_in_por_a: assert property (
        @(posedge sys_clk) !por_main_b |-> !proc_rst_b && !periph_rst_b)
        else $error("Reset released while supply POR is active.");

    sync_delay_a: assert property (
        @(posedge sys_clk) disable iff (!seq_rst_b)
        $rose(por_main_b) |-> !proc_clk_en [*3] ##1 proc_clk_en)
        else $error("Clock not enabled just after the POR synchroniser.");

    window_len_a: assert property (
        @(posedge sys_clk) disable iff (!seq_rst_b)
        $rose(proc_clk_en) |-> !proc_rst_b [*2] ##1 proc_rst_b)
        else $error("Clock window is not two cycles long.");

    release_together_a: assert property (
        @(posedge sys_clk) proc_rst_b == periph_rst_b)
        else $error("Processor and peripheral resets split.");

    cause_update_a: assert property (
        @(posedge sys_clk) disable iff (!rst_int_b)
        $rose(proc_rst_b) |-> reset_cause_field == wrs_pkg::CAUSE_WAKEUP)
        else $error("Cause field not wakeup on release.");

    fall_now_a: assert property (
        @(posedge sys_clk) disable iff (!rst_int_b)
        $fell(por_main_b) |-> !proc_rst_b && !proc_clk_en)
        else $error("Resets not asserted at once on supply fall.");

    clk_before_rel_a: assert property (
        @(posedge sys_clk) disable iff (!seq_rst_b)
        $rose(proc_rst_b) |-> $past(proc_clk_en, 2))
        else $error("Reset released without the clock window.");

    onehot_state_a: assert property (
        @(posedge sys_clk) disable iff (!seq_rst_b) $onehot(state_reg))
        else $error("Sequence state is not one-hot.");

    hold_clk_off_a: assert property (
        @(posedge sys_clk) disable iff (!seq_rst_b)
        state_reg == wrs_pkg::WRS_HOLD && !por_sync |=> !proc_clk_en)
        else $error("Clock enabled while still waiting for the POR.");

    clk_after_sync_a: assert property (
        @(posedge sys_clk) disable iff (!seq_rst_b)
        $rose(proc_clk_en) |-> $past(por_sync))
        else $error("Clock enabled without the synchronised POR.");

    release_stands_a: assert property (
        @(posedge sys_clk) disable iff (!seq_rst_b)
        proc_rst_b |=> proc_rst_b && proc_clk_en)
        else $error("Released reset dropped while the supply was up.");

    cause_kept_a: assert property (
        @(posedge sys_clk) disable iff (!rst_int_b)
        reset_cause_field == wrs_pkg::CAUSE_WAKEUP
        |=> reset_cause_field == wrs_pkg::CAUSE_WAKEUP)
        else $error("Wakeup cause lost while the block was out of reset.");

    cause_code_a: assert property (
        @(posedge sys_clk) disable iff (!rst_int_b)
        reset_cause_field == wrs_pkg::CAUSE_NONE
        || reset_cause_field == wrs_pkg::CAUSE_WAKEUP)
        else $error("Cause field holds an unknown code.");

    // ------------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------------

    seq_done_c: cover property (@(posedge sys_clk) $rose(proc_rst_b));
    window_c: cover property (@(posedge sys_clk) $rose(proc_clk_en));
    supply_drop_c: cover property (
        @(posedge sys_clk) proc_rst_b ##1 !por_main_b);
    glitch_restart_c: cover property (
        @(posedge sys_clk) proc_clk_en && !proc_rst_b ##1 !por_main_b);

endmodule

// ---- verif/wrs_core_model.sv ----
// Behavioural processor core reset input that counts its clock window.
`timescale 1ns/100ps
module wrs_core_model
(
    input  wire logic sys_clk,
    input  wire logic proc_rst_b,
    input  wire logic proc_clk_en,
    output int        core_clks
);
    // The core needs clock edges under reset before it may leave reset.
    // The count freezes at release so the bench can read it afterwards.
    always @(posedge sys_clk)
    begin
        if (!proc_rst_b && proc_clk_en)
            core_clks <= core_clks + 1;
        else if (!proc_rst_b)
            core_clks <= 0;
    end
endmodule

// ---- verif/wakeup_reset_sequencer_tb_top.sv ----
// Self-checking bench for the wakeup reset sequencer.
`timescale 1ns/100ps
`define CHK(got, exp, what) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("BAD %0t %s", $time, what); \
        end \
    end
module wakeup_reset_sequencer_tb_top;
    localparam int WIN = wrs_pkg::CLK_WINDOW_CYCLES;
    logic                         sys_clk;
    logic                         rst_b;
    logic                         por_main_b;
    logic                         proc_rst_b;
    logic                         periph_rst_b;
    logic                         proc_clk_en;
    logic [wrs_pkg::CAUSE_W-1:0]  reset_cause_field;
    logic [wrs_pkg::CAUSE_W-1:0]  cause_exp;
    int                           core_clks;
    int                           n_mismatch;
    int                           checks_done;
    int                           seed;
    int                           i;

    wrs_top #(.WINDOW_CYCLES(WIN)) dut
    (
        .sys_clk           (sys_clk),
        .rst_b             (rst_b),
        .por_main_b        (por_main_b),
        .proc_rst_b        (proc_rst_b),
        .periph_rst_b      (periph_rst_b),
        .proc_clk_en       (proc_clk_en),
        .reset_cause_field (reset_cause_field)
    );

    wrs_core_model core
    (
        .sys_clk     (sys_clk),
        .proc_rst_b  (proc_rst_b),
        .proc_clk_en (proc_clk_en),
        .core_clks   (core_clks)
    );

    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Supply steps
    // ------------------------------------------------------------------
    // Raise the supply and follow the expected sequence edge by edge.
    task automatic power_up(input int n_edges);
        por_main_b = 1'b1;
        for (int k = 1; k <= n_edges; k++)
        begin
            @(negedge sys_clk);
            if (k >= 3 + WIN)
                cause_exp = wrs_pkg::CAUSE_WAKEUP;
            `CHK(proc_clk_en, (k >= 3), "clock window")
            `CHK(proc_rst_b, (k >= 3 + WIN), "proc release")
            `CHK(periph_rst_b, (k >= 3 + WIN), "periph release")
            `CHK(reset_cause_field, cause_exp, "cause")
        end
        if (n_edges >= 3 + WIN)
            `CHK(core_clks == WIN, 1'b1, "core clocks")
    endtask

    // Drop the supply between edges; resets must fall with no clock edge.
    task automatic power_down();
        por_main_b = 1'b0;
        #1;
        `CHK(proc_rst_b, 1'b0, "fall proc")
        `CHK(periph_rst_b, 1'b0, "fall periph")
        `CHK(proc_clk_en, 1'b0, "fall clock")
        repeat (1 + $unsigned($random(seed)) % 4) @(negedge sys_clk);
        `CHK(periph_rst_b, 1'b0, "held low")
        `CHK(reset_cause_field, cause_exp, "cause kept")
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial
    begin
        #50us;
        n_mismatch++;
        conclude();
    end

    initial
    begin
        seed = 26290;
        n_mismatch = 0;
        checks_done = 0;
        rst_b = 1'b0;
        por_main_b = 1'b0;
        cause_exp = wrs_pkg::CAUSE_NONE;
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge sys_clk);
        `CHK(proc_rst_b, 1'b0, "held by supply")
        `CHK(reset_cause_field, cause_exp, "idle cause")
        power_up(8);
        for (i = 0; i < 12; i++)
        begin
            power_down();
            power_up(1 + $unsigned($random(seed)) % 8);
        end
        power_down();
        power_up(8);
        // A second reset in mid-run clears the cause and starts over.
        rst_b = 1'b0;
        cause_exp = wrs_pkg::CAUSE_NONE;
        #1;
        `CHK(reset_cause_field, cause_exp, "reset cause")
        `CHK(proc_rst_b, 1'b0, "reset drops proc")
        `CHK(proc_clk_en, 1'b0, "reset stops clock")
        @(negedge sys_clk);
        rst_b = 1'b1;
        for (i = 0; i < 20 && proc_rst_b !== 1'b1; i++)
            @(negedge sys_clk);
        // Two edges of reset release, then the same path as a power-up.
        `CHK(i, 3 + wrs_pkg::SYNC_STAGES + WIN, "restart edges")
        `CHK(reset_cause_field, wrs_pkg::CAUSE_WAKEUP, "woke")
        `CHK(proc_clk_en, 1'b1, "clock left on")
        conclude();
    end
endmodule
